// ==== bfs_supervisor.sv ====
// Breaker failure supervisor top: Avalon-MM settings, pick-up logic, timers.
// Assumes measured currents and binary signals are synchronous to clk_in.
//
// Overview of operation
// - Start from current, relays, signals, combinations.
// - Current modes evaluate phases and residual.
// - Any internal binary signal can trigger.
// - Selected output relay state triggers.
// - Signal mask active only in signal modes.
// - Relay mask active only in relay modes.
// - Masks static, unaffected by group switching.
// - Node mode On/Blocked/Test/TestBlk/Off, gated globally.
// - Force status override, gated by global enable.
// - Each cycle compare phases and residual.
// - Drop-out at fixed 97 percent.
// - One phase threshold, any phase picks.
// - Group switch changes settings while running.
// - Residual source select, default unused.
// - Mode combines conditions, default current only.
// - Phase threshold step 0.01, default 0.20.
// - Residual threshold step 0.001, default 1.200.
// - Sample block each cycle; blocked replaces start.
// - Retrip after retrip delay, default 0.1s.
// - Failure output after failure delay, default 0.2s.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module bfs_supervisor import bfs_pkg::*; #(
    parameter int unsigned PROC_CYC = PROC_CYCLES,
    parameter int unsigned RETRIP_DEF = RETRIP_MS_DEF,
    parameter int unsigned FAIL_DEF = FAIL_MS_DEF
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire bfs_meas_t meas_in,
    input wire logic [31:0] signals_in,
    input wire logic [15:0] relays_in,
    input wire logic block_in,
    output logic start_out,
    output logic blocked_out,
    output logic retrip_out,
    output logic breaker_failure_output
);
    // Setting groups: two banks so a group switch is a live swap
    bfs_grp_t grp_q [2];
    bfs_grp_t grp_d [2];
    logic grp_sel_q, grp_sel_d;
    logic [31:0] sig_mask_q, sig_mask_d;
    logic [15:0] do_mask_q, do_mask_d;
    logic [2:0] node_q, node_d;
    logic [2:0] force_q, force_d;
    logic allow_node_q, allow_node_d;
    logic allow_force_q, allow_force_d;
    logic [15:0] retrip_ms_q, retrip_ms_d;
    logic [15:0] fail_ms_q, fail_ms_d;
    logic [31:0] rdata_q, rdata_d;
    logic ack_q, ack_d;
    logic cur_pick;
    // Avalon slave: one wait cycle, then answer
    always_comb begin
        grp_d = grp_q;
        grp_sel_d = grp_sel_q;
        sig_mask_d = sig_mask_q;
        do_mask_d = do_mask_q;
        node_d = node_q;
        force_d = force_q;
        allow_node_d = allow_node_q;
        allow_force_d = allow_force_q;
        retrip_ms_d = retrip_ms_q;
        fail_ms_d = fail_ms_q;
        rdata_d = rdata_q;
        ack_d = 1'b0;
        if ((avs_read || avs_write) && !ack_q) begin
            ack_d = 1'b1;
            if (avs_write) begin
                if (avs_address == ADDR_CTRL) begin
                    if (allow_node_q && avs_writedata[2:0] <= 3'(NODE_OFF)) begin
                        node_d = avs_writedata[2:0];
                    end
                    if (allow_force_q && avs_writedata[6:4] <= 3'(FORCE_BLOCKED)) begin
                        force_d = avs_writedata[6:4];
                    end
                end else if (avs_address == ADDR_GLOBAL) begin
                    allow_node_d = avs_writedata[0];
                    allow_force_d = avs_writedata[1];
                    if (!avs_writedata[1]) begin
                        force_d = 3'(FORCE_NORMAL);
                    end
                end else if (avs_address == ADDR_SIGMASK) begin
                    sig_mask_d = avs_writedata;
                end else if (avs_address == ADDR_DOMASK) begin
                    do_mask_d = avs_writedata[15:0];
                end else if (avs_address == ADDR_PHTHR) begin
                    grp_d[avs_writedata[31]].ph_thr = avs_writedata[15:0];
                end else if (avs_address == ADDR_RESTHR) begin
                    grp_d[avs_writedata[31]].res_thr = avs_writedata[15:0];
                end else if (avs_address == ADDR_RETRIP) begin
                    retrip_ms_d = avs_writedata[15:0];
                end else if (avs_address == ADDR_FAIL) begin
                    fail_ms_d = avs_writedata[15:0];
                end else if (avs_address == ADDR_GROUP) begin
                    grp_sel_d = avs_writedata[0];
                    grp_d[avs_writedata[31]].mode = avs_writedata[11:8];
                    grp_d[avs_writedata[31]].res_sel = bfs_res_t'(avs_writedata[5:4]);
                end
            end else begin
                if (avs_address == ADDR_CTRL) begin
                    rdata_d = {25'h0, force_q, 1'b0, node_q};
                end else if (avs_address == ADDR_GLOBAL) begin
                    rdata_d = {30'h0, allow_force_q, allow_node_q};
                end else if (avs_address == ADDR_SIGMASK) begin
                    rdata_d = sig_mask_q;
                end else if (avs_address == ADDR_DOMASK) begin
                    rdata_d = {16'h0, do_mask_q};
                end else if (avs_address == ADDR_PHTHR) begin
                    rdata_d = {16'h0, grp_q[grp_sel_q].ph_thr};
                end else if (avs_address == ADDR_RESTHR) begin
                    rdata_d = {16'h0, grp_q[grp_sel_q].res_thr};
                end else if (avs_address == ADDR_RETRIP) begin
                    rdata_d = {16'h0, retrip_ms_q};
                end else if (avs_address == ADDR_FAIL) begin
                    rdata_d = {16'h0, fail_ms_q};
                end else if (avs_address == ADDR_STATUS) begin
                    rdata_d = {26'h0, cur_pick, breaker_failure_output, retrip_out,
                               blocked_out, start_out, 1'b0};
                end else if (avs_address == ADDR_GROUP) begin
                    rdata_d = {20'h0, grp_q[grp_sel_q].mode, 2'h0,
                               grp_q[grp_sel_q].res_sel, 3'h0, grp_sel_q};
                end else begin
                    rdata_d = RD_UNMAPPED;
                end
            end
        end
    end
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < 2; i++) begin
                grp_q[i] <= '{ph_thr: PH_THR_DEF, res_thr: RES_THR_DEF,
                              mode: MODE_CUR_ONLY, res_sel: RES_UNUSED};
            end
            grp_sel_q <= 1'b0;
            sig_mask_q <= 32'h0000_0000;
            do_mask_q <= 16'h0000;
            node_q <= 3'(NODE_ON);
            force_q <= 3'(FORCE_NORMAL);
            allow_node_q <= 1'b0;
            allow_force_q <= 1'b0;
            retrip_ms_q <= 16'(RETRIP_DEF);
            fail_ms_q <= 16'(FAIL_DEF);
            rdata_q <= 32'h0000_0000;
            ack_q <= 1'b0;
            avs_waitrequest <= 1'b1;
        end else begin
            grp_q <= grp_d;
            grp_sel_q <= grp_sel_d;
            sig_mask_q <= sig_mask_d;
            do_mask_q <= do_mask_d;
            node_q <= node_d;
            force_q <= force_d;
            allow_node_q <= allow_node_d;
            allow_force_q <= allow_force_d;
            retrip_ms_q <= retrip_ms_d;
            fail_ms_q <= fail_ms_d;
            rdata_q <= rdata_d;
            ack_q <= ack_d;
            avs_waitrequest <= !ack_d;
        end
    end
    assign avs_readdata = rdata_q;
    // Processing cycle tick and millisecond time base
    logic [CNT_W-1:0] tick_q, tick_d;
    logic sample, node_off;
    bfs_grp_t grp;
    logic [CUR_W-1:0] res_mag;
    logic [3:0] ph_pick;
    always_comb begin
        sample = (tick_q == CNT_W'(PROC_CYC - 1));
        tick_d = sample ? '0 : tick_q + 1'b1;
        node_off = (node_q == 3'(NODE_OFF));
        grp = grp_q[grp_sel_q];
        case (grp.res_sel)
            RES_MEAS_ONE: res_mag = meas_in.res_one;
            RES_MEAS_TWO: res_mag = meas_in.res_two;
            RES_FROM_PHASES: res_mag = meas_in.res_calc;
            default: res_mag = '0;
        endcase
    end
    bfs_cur_cmp u_ph_a (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .sample_in(sample),
        .clear_in(node_off), .mag_in(meas_in.ph_a), .thr_in(grp.ph_thr),
        .en_in(1'b1), .pick_out(ph_pick[0]));
    bfs_cur_cmp u_ph_b (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .sample_in(sample),
        .clear_in(node_off), .mag_in(meas_in.ph_b), .thr_in(grp.ph_thr),
        .en_in(1'b1), .pick_out(ph_pick[1]));
    bfs_cur_cmp u_ph_c (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .sample_in(sample),
        .clear_in(node_off), .mag_in(meas_in.ph_c), .thr_in(grp.ph_thr),
        .en_in(1'b1), .pick_out(ph_pick[2]));
    bfs_cur_cmp u_res (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .sample_in(sample),
        .clear_in(node_off), .mag_in(res_mag), .thr_in(grp.res_thr),
        .en_in(grp.res_sel != RES_UNUSED), .pick_out(ph_pick[3]));
    assign cur_pick = |ph_pick;
    // Pick-up combination and timers, all advanced on the processing tick
    logic start_q, start_d, blk_q, blk_d, rt_q, rt_d, bf_q, bf_d;
    logic [CNT_W-1:0] ms_div_q, ms_div_d;
    logic [15:0] run_ms_q, run_ms_d;
    logic sig_hit, do_hit, pick;
    logic [2:0] act;
    always_comb begin
        sig_hit = |(signals_in & sig_mask_q);
        do_hit = |(relays_in & do_mask_q);
        act = grp.mode[2:0];
        if (grp.mode[3]) begin
            pick = (act != 3'h0) && (!act[0] || cur_pick) && (!act[1] || sig_hit)
                   && (!act[2] || do_hit);
        end else begin
            pick = (act[0] && cur_pick) || (act[1] && sig_hit) || (act[2] && do_hit);
        end
        start_d = start_q;
        blk_d = blk_q;
        rt_d = rt_q;
        bf_d = bf_q;
        ms_div_d = ms_div_q;
        run_ms_d = run_ms_q;
        if (node_off) begin
            start_d = 1'b0;
            blk_d = 1'b0;
            rt_d = 1'b0;
            bf_d = 1'b0;
            ms_div_d = '0;
            run_ms_d = '0;
        end else if (sample) begin
            if (pick && (block_in || node_q == 3'(NODE_BLOCKED)
                         || node_q == 3'(NODE_TEST_BLOCKED))) begin
                start_d = 1'b0;
                blk_d = 1'b1;
                run_ms_d = '0;
                ms_div_d = '0;
            end else if (pick) begin
                start_d = 1'b1;
                blk_d = 1'b0;
                ms_div_d = ms_div_q + CNT_W'(PROC_CYC);
                if (ms_div_q + CNT_W'(PROC_CYC) >= CNT_W'(PROC_CYCLES)
                    && run_ms_q != 16'hFFFF) begin
                    ms_div_d = ms_div_q + CNT_W'(PROC_CYC) - CNT_W'(PROC_CYCLES);
                    run_ms_d = run_ms_q + 1'b1;
                end
            end else begin
                start_d = 1'b0;
                blk_d = 1'b0;
                run_ms_d = '0;
                ms_div_d = '0;
            end
            rt_d = pick && !blk_d && (run_ms_d >= retrip_ms_q);
            bf_d = pick && !blk_d && (run_ms_d >= fail_ms_q);
        end
    end
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            tick_q <= '0;
            start_q <= 1'b0;
            blk_q <= 1'b0;
            rt_q <= 1'b0;
            bf_q <= 1'b0;
            ms_div_q <= '0;
            run_ms_q <= '0;
            start_out <= 1'b0;
            blocked_out <= 1'b0;
            retrip_out <= 1'b0;
            breaker_failure_output <= 1'b0;
        end else begin
            tick_q <= tick_d;
            start_q <= start_d;
            blk_q <= blk_d;
            rt_q <= rt_d;
            bf_q <= bf_d;
            ms_div_q <= ms_div_d;
            run_ms_q <= run_ms_d;
            case (force_q)
                3'(FORCE_START): {start_out, blocked_out, retrip_out,
                                  breaker_failure_output} <= 4'h8;
                3'(FORCE_RETRIP): {start_out, blocked_out, retrip_out,
                                   breaker_failure_output} <= 4'hA;
                3'(FORCE_FAIL): {start_out, blocked_out, retrip_out,
                                 breaker_failure_output} <= 4'hB;
                3'(FORCE_BLOCKED): {start_out, blocked_out, retrip_out,
                                    breaker_failure_output} <= 4'h4;
                default: {start_out, blocked_out, retrip_out,
                          breaker_failure_output} <= {start_d, blk_d, rt_d, bf_d};
            endcase
        end
    end
    a_off_clears_out: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        node_off && force_q == 3'(FORCE_NORMAL) |=> !start_out && !breaker_failure_output)
        else $error("outputs active while node off");
    a_fail_after_retrip: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        bf_q && fail_ms_q >= retrip_ms_q |-> rt_q)
        else $error("failure without retrip");
    a_blocked_no_start: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        blk_q |-> !start_q)
        else $error("start and blocked together");
    a_retrip_needs_start: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        rt_q |-> start_q && run_ms_q >= retrip_ms_q)
        else $error("retrip before delay");
    a_node_gate_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !allow_node_q |=> $stable(node_q))
        else $error("node mode changed without permission");
    a_force_gate_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !allow_force_q |-> force_q == 3'(FORCE_NORMAL) || $past(allow_force_q))
        else $error("force active without permission");
    a_bus_one_wait: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    a_sig_mask_mode: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        sample && grp.mode == MODE_CUR_ONLY && !cur_pick && !node_off |=> !start_q)
        else $error("signals started current-only mode");
endmodule // bfs_supervisor

// ==== bfs_pkg.sv ====
// Package for the breaker failure supervisor: register map, field codes,
// reset values and timing constants. Assumes a 50 MHz system clock.
package bfs_pkg;
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned PROC_CYCLE_US = 1000;
    localparam int unsigned PROC_CYCLES = PROC_CYCLE_US * (CLK_HZ / 1000000);
    localparam int unsigned RETRIP_MS_DEF = 100;
    localparam int unsigned FAIL_MS_DEF = 200;
    localparam int unsigned CUR_W = 16;
    localparam int unsigned CNT_W = 24;
    localparam logic [15:0] PH_THR_DEF = 16'h0014;
    localparam logic [15:0] RES_THR_DEF = 16'h04B0;
    localparam logic [6:0] RESET_NUM = 7'h61;
    localparam logic [6:0] RESET_DEN = 7'h64;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_GLOBAL = 4'h1;
    localparam logic [3:0] ADDR_SIGMASK = 4'h2;
    localparam logic [3:0] ADDR_DOMASK = 4'h3;
    localparam logic [3:0] ADDR_PHTHR = 4'h4;
    localparam logic [3:0] ADDR_RESTHR = 4'h5;
    localparam logic [3:0] ADDR_RETRIP = 4'h6;
    localparam logic [3:0] ADDR_FAIL = 4'h7;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_GROUP = 4'h9;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

    typedef enum logic [2:0] {
        NODE_ON, NODE_BLOCKED, NODE_TEST, NODE_TEST_BLOCKED, NODE_OFF
    } bfs_node_t;
    typedef enum logic [2:0] {
        FORCE_NORMAL, FORCE_START, FORCE_RETRIP, FORCE_FAIL, FORCE_BLOCKED
    } bfs_force_t;
    typedef enum logic [1:0] {
        RES_UNUSED, RES_MEAS_ONE, RES_MEAS_TWO, RES_FROM_PHASES
    } bfs_res_t;
    // Bit 0 current, bit 1 signals, bit 2 output relay; bit 3 set means AND
    typedef logic [3:0] bfs_mode_t;
    localparam bfs_mode_t MODE_CUR_ONLY = 4'h1;

    typedef struct packed {
        logic [CUR_W-1:0] ph_a;
        logic [CUR_W-1:0] ph_b;
        logic [CUR_W-1:0] ph_c;
        logic [CUR_W-1:0] res_one;
        logic [CUR_W-1:0] res_two;
        logic [CUR_W-1:0] res_calc;
    } bfs_meas_t;
    typedef struct packed {
        logic [CUR_W-1:0] ph_thr;
        logic [CUR_W-1:0] res_thr;
        bfs_mode_t mode;
        bfs_res_t res_sel;
    } bfs_grp_t;
endpackage

// ==== bfs_cur_cmp.sv ====
// Current pick-up element with fixed 97 percent drop-out.
// Assumes magnitudes and thresholds share one fixed-point scale.
`timescale 1ns/1ps
module bfs_cur_cmp import bfs_pkg::*; (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic sample_in,
    input wire logic clear_in,
    input wire logic [CUR_W-1:0] mag_in,
    input wire logic [CUR_W-1:0] thr_in,
    input wire logic en_in,
    output logic pick_out
);
    logic pick_q;
    logic pick_d;
    logic [CUR_W+6:0] mag_scaled;
    logic [CUR_W+6:0] thr_drop;
    always_comb begin
        thr_drop = {7'h00, thr_in} * {16'h0000, RESET_NUM};
        // 97 percent drop-out: mag*100 against thr*97
        mag_scaled = (CUR_W + 7)'({7'h00, mag_in} * {16'h0000, RESET_DEN});
        pick_d = pick_q;
        if (clear_in || !en_in) begin
            pick_d = 1'b0;
        end else if (sample_in) begin
            if (mag_in > thr_in) begin
                pick_d = 1'b1;
            end else if (mag_scaled < thr_drop) begin
                pick_d = 1'b0;
            end
        end
    end
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pick_q <= 1'b0;
        end else begin
            pick_q <= pick_d;
        end
    end
    assign pick_out = pick_q;
    a_pick_drop_ratio: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        pick_q && sample_in && en_in && !clear_in && !(mag_scaled < thr_drop) |=> pick_q)
        else $error("pick-up dropped above 97 percent");
endmodule // bfs_cur_cmp

// ==== bfs_breaker_model.sv ====
// Far-side model: upstream feeder breaker driven by the failure output.
// Assumes the failure command is a level synchronous to clk_in.
`timescale 1ns/1ps
module bfs_breaker_model #(
    parameter int unsigned OPEN_CLKS = 40
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic fail_in,
    output logic feeder_open_out
);
    int unsigned cnt_q;
    // Opens only after the command has stayed up for its operating time
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !fail_in) begin
            cnt_q <= 0;
        end else if (cnt_q < OPEN_CLKS) begin
            cnt_q <= cnt_q + 1;
        end
    end
    assign feeder_open_out = (cnt_q == OPEN_CLKS);
endmodule // bfs_breaker_model

// ==== bfs_supervisor_tb.sv ====
// Self-checking bench for the breaker failure supervisor.
// Assumes the register map of the package; the processing tick is shortened to PC = 50 cycles.
`timescale 1ns/1ps
module bfs_supervisor_tb import bfs_pkg::*;;
    localparam int unsigned PC = 50;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    bfs_meas_t meas = '0;
    logic [31:0] signals = 32'h0;
    logic [15:0] relays = 16'h0;
    logic block = 1'b0;
    logic start_out, blocked_out, retrip_out, breaker_failure_output, feeder_open;
    logic [31:0] rd;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    wire [31:0] outs = {28'h0, start_out, blocked_out, retrip_out, breaker_failure_output};

    bfs_supervisor #(.PROC_CYC(PC)) dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .meas_in(meas), .signals_in(signals),
        .relays_in(relays), .block_in(block), .start_out(start_out),
        .blocked_out(blocked_out), .retrip_out(retrip_out),
        .breaker_failure_output(breaker_failure_output));
    bfs_breaker_model brk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .fail_in(breaker_failure_output), .feeder_open_out(feeder_open));

    always #10 clk_in = ~clk_in;

    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Hang guard: the timer test dominates at about 50000 cycles
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk_in);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    task automatic grp(input bfs_mode_t m, input bfs_res_t r);
        bus(1'b1, ADDR_GROUP, {20'h0, m, 2'h0, r, 4'h0});
    endtask

    task automatic ticks(input int n);
        repeat (n * PC) @(posedge clk_in);
    endtask

    task automatic t_defaults;
        rchk(ADDR_PHTHR, {16'h0, PH_THR_DEF});
        rchk(ADDR_RESTHR, {16'h0, RES_THR_DEF});
        rchk(ADDR_RETRIP, 32'h64);
        rchk(ADDR_FAIL, 32'hC8);
        rchk(ADDR_CTRL, 32'h0);
        rchk(ADDR_GROUP, 32'h100);
        bus(1'b1, 4'hF, 32'hFFFF_FFFF);
        rchk(4'hF, RD_UNMAPPED);
        $display("test defaults done");
    endtask

    task automatic t_phase;
        meas.ph_c <= 16'h03E8;
        ticks(3);
        check(outs, 32'h8);
        rchk(ADDR_STATUS, 32'h22);
        meas <= '0;
        ticks(3);
        check(outs, 32'h0);
        $display("test phase done");
    endtask

    task automatic t_resid;
        grp(MODE_CUR_ONLY, RES_MEAS_ONE);
        meas.res_two <= 16'h07D0;
        ticks(3);
        check(outs, 32'h0);
        meas.res_one <= 16'h0514;
        ticks(3);
        check(outs, 32'h8);
        meas.res_one <= 16'h049C;
        ticks(3);
        check(outs, 32'h8);
        meas.res_one <= 16'h047E;
        ticks(3);
        check(outs, 32'h0);
        meas <= '0;
        grp(MODE_CUR_ONLY, RES_UNUSED);
        $display("test residual done");
    endtask

    task automatic t_sig_relay;
        bus(1'b1, ADDR_SIGMASK, 32'h8);
        bus(1'b1, ADDR_DOMASK, 32'h1);
        signals <= 32'h8;
        ticks(3);
        check(outs, 32'h0);
        grp(4'h2, RES_UNUSED);
        ticks(3);
        check(outs, 32'h8);
        signals <= 32'h10;
        ticks(3);
        check(outs, 32'h0);
        grp(4'hD, RES_UNUSED);
        relays <= 16'h1;
        ticks(3);
        check(outs, 32'h0);
        meas.ph_a <= 16'h03E8;
        ticks(3);
        check(outs, 32'h8);
        relays <= 16'h2;
        ticks(3);
        check(outs, 32'h0);
        grp(4'h5, RES_UNUSED);
        meas <= '0;
        relays <= 16'h1;
        ticks(3);
        check(outs, 32'h8);
        relays <= 16'h0;
        grp(MODE_CUR_ONLY, RES_UNUSED);
        $display("test signals relays done");
    endtask

    task automatic t_block_node;
        meas.ph_a <= 16'h03E8;
        block <= 1'b1;
        ticks(3);
        check(outs, 32'h4);
        block <= 1'b0;
        bus(1'b1, ADDR_CTRL, 32'h4);
        rchk(ADDR_CTRL, 32'h0);
        bus(1'b1, ADDR_GLOBAL, 32'h1);
        bus(1'b1, ADDR_CTRL, 32'h34);
        rchk(ADDR_CTRL, 32'h4);
        ticks(3);
        check(outs, 32'h0);
        rchk(ADDR_STATUS, 32'h0);
        bus(1'b1, ADDR_CTRL, 32'h0);
        ticks(3);
        check(outs, 32'h8);
        meas <= '0;
        bus(1'b1, ADDR_GLOBAL, 32'h3);
        bus(1'b1, ADDR_CTRL, 32'h30);
        ticks(3);
        check({31'h0, breaker_failure_output}, 32'h1);
        bus(1'b1, ADDR_CTRL, 32'h0);
        bus(1'b1, ADDR_GLOBAL, 32'h0);
        ticks(3);
        check(outs, 32'h0);
        $display("test block node force done");
    endtask

    // Delays count whole milliseconds of the full-rate tick
    task automatic t_timers;
        int n;
        n = 0;
        bus(1'b1, ADDR_RETRIP, 32'h0);
        bus(1'b1, ADDR_FAIL, 32'h1);
        meas.ph_a <= 16'h03E8;
        ticks(3);
        check(outs, 32'hA);
        while (breaker_failure_output !== 1'b1 && n < 60000) begin
            @(posedge clk_in);
            n++;
        end
        check({31'h0, n > 45000 && n < 50000}, 32'h1);
        while (feeder_open !== 1'b1 && n < 60000) begin
            @(posedge clk_in);
            n++;
        end
        check({31'h0, feeder_open}, 32'h1);
        meas <= '0;
        ticks(3);
        check(outs, 32'h0);
        bus(1'b1, ADDR_GROUP, 32'h101);
        rchk(ADDR_GROUP, 32'h101);
        rchk(ADDR_SIGMASK, 32'h8);
        rchk(ADDR_DOMASK, 32'h1);
        $display("test timers done");
    endtask

    initial begin
        repeat (16) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_defaults();
        t_phase();
        t_resid();
        t_sig_relay();
        t_block_node();
        t_timers();
        wrap_up();
    end
endmodule // bfs_supervisor_tb
